// [hw/sbs_defines.svh]
// timing counts, widths and codes shared by both ends of the bus sequencer
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH
`define SBS_ADR_W 32
`define SBS_DATA_W 128
`define SBS_CHECK_W 28
`define SBS_MASK_W 8
`define SBS_REQ_W 3
`define SBS_ACK_W 3
// system clock divide: cpu cycles per half period of the system clock
`define SBS_SYS_HALF 2
// cpu cycles the address settles ahead of the start edge
`define SBS_ADR_SETUP 1
// external logic: cycles from command seen to acknowledge (prefetch/ordering_sync_request)
`define SBS_ACK_DELAY 1
`define SBS_LOCKED_BIT 0
// cycles from a word select change until the upper chunk reaches the
// external end's second flop: two cpu syncs, the drive flop, two ext syncs
`define SBS_PULL_LAG 5
// 16-byte beats returned for one block read
`define SBS_READ_BEATS 2
`endif

// [hw/sbs_pkg.sv]
// types shared by both ends of the system bus sequencer
package sbs_pkg;
  typedef enum logic [2:0] {
    SBS_REQ_IDLE = 3'h0,
    SBS_REQ_ORDERING_SYNC_REQUEST = 3'h1,
    SBS_REQ_FETCH = 3'h2,
    SBS_REQ_MOD_HINT = 3'h3,
    SBS_REQ_WRITE = 3'h4,
    SBS_REQ_COND_ST = 3'h5,
    SBS_REQ_READ = 3'h6,
    SBS_REQ_LOCKED = 3'h7
  } sbs_req_t;
  typedef enum logic [2:0] {
    SBS_ACK_IDLE = 3'h0,
    SBS_ACK_HARD_ERR = 3'h1,
    SBS_ACK_COND_REJECT = 3'h2,
    SBS_ACK_SOFT_ERR = 3'h3,
    SBS_ACK_OK = 3'h4
  } sbs_ack_t;
endpackage

// [hw/sbs_if.sv]
// pins between the cpu end and the external system controller end
`include "sbs_defines.svh"
interface sbs_if;
  logic system_clock_out;
  logic [`SBS_ADR_W-1:0] adr;
  logic [`SBS_REQ_W-1:0] command_request_lines;
  logic [`SBS_MASK_W-1:0] write_mask_lines;
  logic data_output_enable_n;
  logic data_word_select;
  logic [`SBS_ACK_W-1:0] cycle_acknowledge_code;
  logic read_data_ack;
  logic [1:0] data_ram_address_bits;
  logic [3:0] data_ram_enables;
  logic tag_ram_enable;
  // shared data and check buses: each end gives output and enable
  logic [`SBS_DATA_W-1:0] cpu_data_o;
  logic [`SBS_CHECK_W-1:0] cpu_check_o;
  logic cpu_data_oe;
  logic [`SBS_DATA_W-1:0] ext_data_o;
  logic [`SBS_CHECK_W-1:0] ext_check_o;
  logic ext_data_oe;
  logic [`SBS_DATA_W-1:0] data_i;
  logic [`SBS_CHECK_W-1:0] check_i;
  // resolved bus level; the cpu wins an overlap, which is a bench fault
  assign data_i = cpu_data_oe ? cpu_data_o :
                  ext_data_oe ? ext_data_o : '0;
  assign check_i = cpu_data_oe ? cpu_check_o :
                   ext_data_oe ? ext_check_o : '0;
  modport cpu (
    output system_clock_out, adr, command_request_lines, write_mask_lines,
    output data_ram_address_bits, data_ram_enables, tag_ram_enable,
    output cpu_data_o, cpu_check_o, cpu_data_oe,
    input data_output_enable_n, data_word_select, cycle_acknowledge_code,
    input read_data_ack, data_i, check_i
  );
  modport ext (
    input system_clock_out, adr, command_request_lines, write_mask_lines,
    input data_ram_address_bits, data_ram_enables, tag_ram_enable,
    input cpu_data_o, cpu_check_o, cpu_data_oe, data_i, check_i,
    output data_output_enable_n, data_word_select, cycle_acknowledge_code,
    output read_data_ack, ext_data_o, ext_check_o, ext_data_oe
  );
endinterface

// [hw/sbs_cpu_end.sv]
// cpu end: sequences block write, locked load, ordering_sync_request and prefetch hints
`include "sbs_defines.svh"
module sbs_cpu_end (
  input wire logic clk,
  input wire logic rst,
  sbs_if.cpu bus,
  input wire logic req_valid,
  input wire sbs_pkg::sbs_req_t req_kind,
  input wire logic [`SBS_ADR_W-1:0] req_adr,
  input wire logic [`SBS_MASK_W-1:0] req_mask,
  input wire logic [2*`SBS_DATA_W-1:0] req_wdata,
  input wire logic cache_hit,
  input wire logic cache_shared,
  input wire logic cache_enabled,
  output logic req_ready,
  output logic done,
  output logic [`SBS_ACK_W-1:0] done_ack,
  output logic [`SBS_DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic rd_check_err
);
  import sbs_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_AFTER = 4'b1000
  } sbs_cpu_state_t;

  sbs_cpu_state_t state_q;
  sbs_req_t cmd_q;
  logic [`SBS_ADR_W-1:0] adr_q;
  logic [`SBS_MASK_W-1:0] mask_q;
  logic [2*`SBS_DATA_W-1:0] wdata_q;
  logic [`SBS_REQ_W-1:0] req_lines_q;
  logic [`SBS_MASK_W-1:0] mask_lines_q;
  logic ram_ctl_q;
  logic [3:0] data_en_q;
  logic sys_q;
  logic [1:0] div_q;
  logic doe_n_s1, doe_n_s2, wsel_s1, wsel_s2, rack_s1, rack_s2;
  logic [`SBS_ACK_W-1:0] ack_s1, ack_s2;
  logic [`SBS_DATA_W-1:0] din_s1, din_s2;
  logic [`SBS_CHECK_W-1:0] cin_s1, cin_s2;
  logic [`SBS_DATA_W-1:0] dout_q;
  logic [`SBS_CHECK_W-1:0] cout_q;
  logic oe_q;
  logic ready_q, done_q, rd_valid_q, rd_err_q;
  logic [`SBS_ACK_W-1:0] done_ack_q;
  logic [`SBS_DATA_W-1:0] rd_data_q;

  // check bits: 28 per 128-bit chunk, bit i the parity of the chunk shifted right by i times 5 modulo 128, xor data bit i
  function automatic logic [`SBS_CHECK_W-1:0] gen_check(
    input logic [`SBS_DATA_W-1:0] d
  );
    logic [`SBS_CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < `SBS_CHECK_W; i++) begin
      c[i] = ^(d >> ((i * 5) % `SBS_DATA_W)) ^ d[i];
    end
    return c;
  endfunction

  // system clock edge: rising edge of the divided clock marks a start
  wire div_wrap = (div_q == 2'(`SBS_SYS_HALF - 1));
  wire sys_rise = div_wrap && !sys_q;
  // plain block write on miss, cache off or shared hit
  wire want_write = !cache_hit || !cache_enabled || cache_shared;
  wire is_write = (cmd_q == SBS_REQ_WRITE) || (cmd_q == SBS_REQ_COND_ST);
  wire take_write = (req_kind == SBS_REQ_WRITE) ||
                    (req_kind == SBS_REQ_COND_ST);
  wire is_read = (cmd_q == SBS_REQ_READ) || (cmd_q == SBS_REQ_LOCKED);
  wire acked = (ack_s2 != `SBS_ACK_W'(SBS_ACK_IDLE));
  wire pull = !doe_n_s2 && is_write && (state_q == ST_ACTIVE);
  wire [`SBS_DATA_W-1:0] chunk = wsel_s2 ? wdata_q[2*`SBS_DATA_W-1:
                                                   `SBS_DATA_W]
                                         : wdata_q[`SBS_DATA_W-1:0];
  wire req_take = ready_q && req_valid &&
                  ((req_kind != SBS_REQ_WRITE) || want_write);

  // input pins pass two flops before any logic reads them
  always_ff @(posedge clk) begin
    doe_n_s1 <= bus.data_output_enable_n;
    doe_n_s2 <= doe_n_s1;
    wsel_s1 <= bus.data_word_select;
    wsel_s2 <= wsel_s1;
    rack_s1 <= bus.read_data_ack;
    rack_s2 <= rack_s1;
    ack_s1 <= bus.cycle_acknowledge_code;
    ack_s2 <= ack_s1;
    din_s1 <= bus.data_i;
    din_s2 <= din_s1;
    cin_s1 <= bus.check_i;
    cin_s2 <= cin_s1;
  end

  // system clock divider driven out as a pin
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 2'h0;
      sys_q <= 1'b0;
    end else begin
      div_q <= div_wrap ? 2'h0 : div_q + 2'h1;
      if (div_wrap) sys_q <= !sys_q;
    end
  end

  // transaction sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_q <= SBS_REQ_IDLE;
      adr_q <= '0;
      mask_q <= '0;
      wdata_q <= '0;
      req_lines_q <= `SBS_REQ_W'(SBS_REQ_IDLE);
      mask_lines_q <= '0;
      ram_ctl_q <= 1'b1;
      data_en_q <= 4'hf;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      done_ack_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ready_q <= 1'b1;
          if (req_take) begin
            ready_q <= 1'b0;
            cmd_q <= req_kind;
            // enables off a full cycle before a write can start
            if (take_write) data_en_q <= 4'h0;
            // address placed now, well ahead of the start
            adr_q <= req_adr;
            // at most one quadword for conditional store
            mask_q <= (req_kind == SBS_REQ_COND_ST) ? (req_mask & 8'h03)
                                                    : req_mask;
            wdata_q <= req_wdata;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // command held idle until the start edge
          req_lines_q <= `SBS_REQ_W'(SBS_REQ_IDLE);
          // data enables off ahead of the start edge on writes
          if (is_write) data_en_q <= 4'h0;
          if (sys_rise) begin
            // mask and code appear together
            req_lines_q <= cmd_q;
            mask_lines_q <= mask_q;
            // remaining ram controls let go at the start
            ram_ctl_q <= 1'b0;
            data_en_q <= 4'h0;
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          // acknowledge ends every kind; reject ends store too
          if (acked) begin
            // withdraw address and command
            req_lines_q <= `SBS_REQ_W'(SBS_REQ_IDLE);
            mask_lines_q <= '0;
            adr_q <= '0;
            done_q <= 1'b1;
            done_ack_q <= ack_s2;
            state_q <= ST_AFTER;
          end
        end
        ST_AFTER: begin
          // one idle cycle before the controls return
          ram_ctl_q <= 1'b1;
          data_en_q <= 4'hf;
          if (!acked) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // write data drive, chunk by word select
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_q <= 1'b0;
      dout_q <= '0;
      cout_q <= '0;
    end else begin
      // bus released unless the enable asks for data
      oe_q <= pull;
      dout_q <= chunk;
      cout_q <= gen_check(chunk);
    end
  end

  // read data capture on read data ack
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      rd_err_q <= 1'b0;
    end else begin
      rd_valid_q <= rack_s2 && is_read && (state_q == ST_ACTIVE);
      if (rack_s2) begin
        rd_data_q <= din_s2;
        rd_err_q <= (gen_check(din_s2) != cin_s2);
      end
    end
  end

  assign bus.system_clock_out = sys_q;
  assign bus.adr = adr_q;
  assign bus.command_request_lines = req_lines_q;
  assign bus.write_mask_lines = mask_lines_q;
  assign bus.data_ram_address_bits = {2{ram_ctl_q}};
  assign bus.data_ram_enables = data_en_q;
  assign bus.tag_ram_enable = ram_ctl_q;
  assign bus.cpu_data_o = dout_q;
  assign bus.cpu_check_o = cout_q;
  assign bus.cpu_data_oe = oe_q;
  assign req_ready = ready_q;
  assign done = done_q;
  assign done_ack = done_ack_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_check_err = rd_err_q;
endmodule

// [hw/sbs_ext_end.sv]
// external controller end: answers commands, pulls write data, acks
`include "sbs_defines.svh"
module sbs_ext_end (
  input wire logic clk,
  input wire logic rst,
  sbs_if.ext bus,
  input wire logic reject_cond_store,
  input wire logic [`SBS_ACK_W-1:0] ack_code,
  input wire logic flush_done,
  input wire logic [`SBS_DATA_W-1:0] mem_rdata,
  output logic wr_valid,
  output logic [`SBS_DATA_W-1:0] wr_data,
  output logic wr_upper,
  output logic cache_we
);
  import sbs_pkg::*;

  typedef enum logic [4:0] {
    EX_IDLE = 5'b00001,
    EX_LOW = 5'b00010,
    EX_HIGH = 5'b00100,
    EX_ACK = 5'b01000,
    EX_WAIT = 5'b10000
  } sbs_ext_state_t;

  sbs_ext_state_t state_q;
  logic [`SBS_REQ_W-1:0] cmd_s1, cmd_s2;
  logic [`SBS_MASK_W-1:0] mask_s1, mask_s2;
  logic oe_s1, oe_s2;
  logic [`SBS_DATA_W-1:0] d_s1, d_s2;
  logic doe_n_q, wsel_q, rack_q, ext_oe_q, wr_valid_q, wr_upper_q, we_q;
  logic [`SBS_ACK_W-1:0] ack_q;
  logic [2:0] cnt_q;
  logic [`SBS_DATA_W-1:0] wr_data_q, rdata_q;
  logic [`SBS_CHECK_W-1:0] rchk_q;

  // same check code as the cpu end, so returned read data checks clean
  function automatic logic [`SBS_CHECK_W-1:0] gen_check(
    input logic [`SBS_DATA_W-1:0] d
  );
    logic [`SBS_CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < `SBS_CHECK_W; i++) begin
      c[i] = ^(d >> ((i * 5) % `SBS_DATA_W)) ^ d[i];
    end
    return c;
  endfunction

  wire sbs_req_t cmd = sbs_req_t'(cmd_s2);
  wire is_write = (cmd == SBS_REQ_WRITE) || (cmd == SBS_REQ_COND_ST);
  wire is_read = (cmd == SBS_REQ_READ) || (cmd == SBS_REQ_LOCKED);
  // pull only chunks holding valid longwords
  wire low_valid = |mask_s2[3:0];
  wire high_valid = |mask_s2[7:4];
  wire reject = (cmd == SBS_REQ_COND_ST) && reject_cond_store;
  wire [`SBS_ACK_W-1:0] final_ack = reject ?
      `SBS_ACK_W'(SBS_ACK_COND_REJECT) : ack_code;

  // cpu outputs pass two flops before use
  always_ff @(posedge clk) begin
    cmd_s1 <= bus.command_request_lines;
    cmd_s2 <= cmd_s1;
    mask_s1 <= bus.write_mask_lines;
    mask_s2 <= mask_s1;
    oe_s1 <= bus.cpu_data_oe;
    oe_s2 <= oe_s1;
    d_s1 <= bus.data_i;
    d_s2 <= d_s1;
  end

  // answer sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= EX_IDLE;
      doe_n_q <= 1'b1;
      wsel_q <= 1'b0;
      ack_q <= '0;
      rack_q <= 1'b0;
      ext_oe_q <= 1'b0;
      cnt_q <= 3'h0;
      wr_valid_q <= 1'b0;
      wr_upper_q <= 1'b0;
      we_q <= 1'b0;
      wr_data_q <= '0;
      rdata_q <= '0;
      rchk_q <= '0;
    end else begin
      wr_valid_q <= 1'b0;
      we_q <= 1'b0;
      rack_q <= 1'b0;
      ext_oe_q <= 1'b0;
      case (state_q)
        EX_IDLE: begin
          cnt_q <= 3'h0;
          if (cmd != SBS_REQ_IDLE) begin
            if (is_write && !reject && low_valid) begin
              doe_n_q <= 1'b0;
              state_q <= EX_LOW;
            end else if (is_write && !reject && high_valid) begin
              doe_n_q <= 1'b0;
              wsel_q <= 1'b1;
              state_q <= EX_HIGH;
            end else begin
              state_q <= EX_ACK;
            end
          end
        end
        EX_LOW: begin
          if (oe_s2 && !wsel_q) begin
            wr_valid_q <= 1'b1;
            wr_upper_q <= 1'b0;
            wr_data_q <= d_s2;
            we_q <= 1'b1;
            // lower chunk done, upper next if valid
            if (high_valid) begin
              wsel_q <= 1'b1;
              state_q <= EX_HIGH;
            end else begin
              doe_n_q <= 1'b1;
              state_q <= EX_ACK;
            end
          end
        end
        EX_HIGH: begin
          // lower chunk still in the pipe: wait for the upper one to land
          if (oe_s2 && wsel_q && cnt_q == 3'(`SBS_PULL_LAG)) begin
            wr_valid_q <= 1'b1;
            wr_upper_q <= 1'b1;
            wr_data_q <= d_s2;
            we_q <= 1'b1;
            doe_n_q <= 1'b1;
            wsel_q <= 1'b0;
            state_q <= EX_ACK;
          end else if (cnt_q != 3'(`SBS_PULL_LAG)) begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        EX_ACK: begin
          if (is_read && cnt_q != 3'(`SBS_READ_BEATS)) begin
            // one 16-byte beat a cycle, each with its ack
            rdata_q <= mem_rdata;
            rchk_q <= gen_check(mem_rdata);
            ext_oe_q <= 1'b1;
            rack_q <= 1'b1;
            cnt_q <= cnt_q + 3'h1;
          end else if (cmd != SBS_REQ_ORDERING_SYNC_REQUEST || flush_done) begin
            // ordering_sync_request acked only once flushed hints always
            ack_q <= final_ack;
            state_q <= EX_WAIT;
          end
        end
        EX_WAIT: begin
          // drop ack once command withdrawn
          if (cmd == SBS_REQ_IDLE) begin
            ack_q <= '0;
            state_q <= EX_IDLE;
          end
        end
        default: state_q <= EX_IDLE;
      endcase
    end
  end

  assign bus.data_output_enable_n = doe_n_q;
  assign bus.data_word_select = wsel_q;
  assign bus.cycle_acknowledge_code = ack_q;
  assign bus.read_data_ack = rack_q;
  assign bus.ext_data_o = rdata_q;
  assign bus.ext_check_o = rchk_q;
  assign bus.ext_data_oe = ext_oe_q;
  assign wr_valid = wr_valid_q;
  assign wr_data = wr_data_q;
  assign wr_upper = wr_upper_q;
  assign cache_we = we_q;
endmodule

// [tb/sbs_properties.sv]
// pin-level assertions on the bus joining the cpu end and the external end
`include "sbs_defines.svh"
module sbs_properties
  import sbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SBS_ADR_W-1:0] adr,
  input wire logic [`SBS_REQ_W-1:0] command_request_lines,
  input wire logic [`SBS_MASK_W-1:0] write_mask_lines,
  input wire logic data_output_enable_n,
  input wire logic [`SBS_ACK_W-1:0] cycle_acknowledge_code,
  input wire logic [1:0] data_ram_address_bits,
  input wire logic [3:0] data_ram_enables,
  input wire logic tag_ram_enable,
  input wire logic cpu_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // named decodes of the command and acknowledge codes
  wire logic cmd_on = command_request_lines != SBS_REQ_IDLE;
  wire logic ack_on = cycle_acknowledge_code != 3'h0;
  wire logic is_wr = command_request_lines == SBS_REQ_WRITE;
  wire logic is_hint = command_request_lines == SBS_REQ_FETCH ||
                       command_request_lines == SBS_REQ_MOD_HINT;
  wire logic ctl_free = data_ram_enables == 4'h0 && !tag_ram_enable &&
                        data_ram_address_bits == 2'h0;
  // cycles the pull enable has stood high; the drive may lag by a few
  logic [2:0] off_q;
  always_ff @(posedge clk) begin
    if (rst || !data_output_enable_n) begin
      off_q <= 3'h0;
    end else if (off_q != 3'h7) begin
      off_q <= off_q + 3'h1;
    end
  end
  a_idle_before_start:
  assert property ($rose(cmd_on) |-> $past(command_request_lines, 2) == 3'h0
    && $past(command_request_lines, 4) == 3'h0)
    else $error("command not idle through the cycle before start");
  a_adr_settled:
  assert property ($rose(cmd_on) |-> $stable(adr))
    else $error("address moved at the start edge");
  a_write_ctl_free:
  assert property ($rose(is_wr) |-> $past(data_ram_enables) == 4'h0
    ##[0:1] ctl_free)
    else $error("ram controls not released around write start");
  a_hint_ctl_free:
  assert property ($rose(is_hint) |-> ##[0:1] ctl_free)
    else $error("ram controls not released for prefetch hint");
  a_cmd_holds_ack:
  assert property ($fell(cmd_on) |-> ack_on || $past(ack_on) ||
    $past(ack_on, 2) || $past(ack_on, 3))
    else $error("command removed without an acknowledge");
  a_ack_ends_cmd:
  assert property ($rose(ack_on) && cmd_on |-> ##[1:6] !cmd_on)
    else $error("command not withdrawn after acknowledge");
  a_idle_after:
  assert property ($past(cmd_on) && $changed(command_request_lines)
    |-> !cmd_on)
    else $error("command went straight to another command");
  a_ack_removed:
  assert property ($fell(cmd_on) |-> ##[0:4] !ack_on)
    else $error("acknowledge kept after command removed");
  a_cond_mask:
  assert property (command_request_lines == SBS_REQ_COND_ST |->
    (write_mask_lines & 8'hfc) == 8'h00)
    else $error("conditional store mask beyond one quadword");
  a_drive_off:
  assert property (off_q >= 3'h4 |-> !cpu_data_oe)
    else $error("data driven while not pulled");
endmodule

// [tb/cpu_system_bus_transaction_sequencer_tb.sv]
// self-checking bench: cpu end and external end face each other on the bus
`include "sbs_defines.svh"
module cpu_system_bus_transaction_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  sbs_req_t req_kind = SBS_REQ_IDLE;
  logic [31:0] req_adr = 32'h0;
  logic [7:0] req_mask = 8'h0;
  logic [255:0] req_wdata = {128'hfedcba98_76543210_0f1e2d3c_4b5a6978,
                             128'h01234567_89abcdef_a5a5c3c3_5a5a3c3c};
  logic cache_hit = 1'b0, cache_shared = 1'b0, cache_enabled = 1'b0;
  logic reject_cond_store = 1'b0, flush_done = 1'b1;
  logic [2:0] ack_code = SBS_ACK_OK;
  logic [127:0] mem_rdata = 128'h13572468_9bdfeca8_00ff00ff_c0ffee11;
  logic req_ready, done, rd_valid, rd_check_err, wr_valid, wr_upper, cache_we;
  logic [2:0] done_ack, seen_ack, seen_cmd, prev_cmd = 3'h0;
  logic [7:0] seen_mask;
  logic [31:0] seen_adr;
  logic [127:0] rd_data, wr_data, seen_rd;
  logic [128:0] chunks[$];
  int mismatches = 0, checks_done = 0;
  int done_cnt = 0, rd_cnt = 0, we_cnt = 0, start_cnt = 0;
  sbs_ack_t codes[3] = '{SBS_ACK_OK, SBS_ACK_SOFT_ERR, SBS_ACK_HARD_ERR};

  sbs_if bus_if();
  sbs_cpu_end sbs_cpu_end_i (.clk(clk), .rst(rst), .bus(bus_if),
    .req_valid(req_valid), .req_kind(req_kind), .req_adr(req_adr),
    .req_mask(req_mask), .req_wdata(req_wdata), .cache_hit(cache_hit),
    .cache_shared(cache_shared), .cache_enabled(cache_enabled),
    .req_ready(req_ready), .done(done), .done_ack(done_ack),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_check_err(rd_check_err));
  sbs_ext_end sbs_ext_end_i (.clk(clk), .rst(rst), .bus(bus_if),
    .reject_cond_store(reject_cond_store), .ack_code(ack_code),
    .flush_done(flush_done), .mem_rdata(mem_rdata), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_upper(wr_upper), .cache_we(cache_we));
  sbs_properties sbs_properties_i (.clk(clk), .rst(rst), .adr(bus_if.adr),
    .command_request_lines(bus_if.command_request_lines),
    .write_mask_lines(bus_if.write_mask_lines),
    .data_output_enable_n(bus_if.data_output_enable_n),
    .cycle_acknowledge_code(bus_if.cycle_acknowledge_code),
    .data_ram_address_bits(bus_if.data_ram_address_bits),
    .data_ram_enables(bus_if.data_ram_enables),
    .tag_ram_enable(bus_if.tag_ram_enable),
    .cpu_data_oe(bus_if.cpu_data_oe));

  // free-running cpu clock, 10 ns period
  initial begin
    forever #5 clk = ~clk;
  end

  // monitor: completions, pulled chunks, read data and each opening command
  always @(posedge clk) begin
    if (done) begin
      done_cnt++;
      seen_ack = done_ack;
    end
    if (wr_valid) chunks.push_back({wr_upper, wr_data});
    if (rd_valid) begin
      rd_cnt++;
      seen_rd = rd_data;
    end
    if (cache_we) we_cnt++;
    if (bus_if.command_request_lines != 3'h0 && prev_cmd == 3'h0) begin
      start_cnt++;
      seen_cmd = bus_if.command_request_lines;
      seen_mask = bus_if.write_mask_lines;
      seen_adr = bus_if.adr;
    end
    prev_cmd = bus_if.command_request_lines;
  end

  task automatic check(string what, logic [255:0] seen, logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one transaction: offer it, wait for completion, compare what crossed
  task automatic run_op(sbs_req_t k, logic [31:0] a, logic [7:0] m,
                        logic [2:0] ack);
    int i, base, rbase, n;
    logic wr;
    base = done_cnt;
    rbase = rd_cnt;
    chunks.delete();
    req_kind = k;
    req_adr = a;
    req_mask = m;
    ack_code = ack;
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) tick();
    req_valid = 1'b1;
    for (i = 0; i < 300 && req_ready === 1'b1; i++) tick();
    req_valid = 1'b0;
    for (i = 0; i < 400 && done_cnt == base; i++) tick();
    wr = (k == SBS_REQ_WRITE || k == SBS_REQ_COND_ST);
    n = (wr && ack != SBS_ACK_COND_REJECT) ? (m[3:0] != 0) + (m[7:4] != 0) : 0;
    check("done count", done_cnt - base, 1);
    check("ack code", seen_ack, ack);
    check("command code", seen_cmd, k);
    check("address", seen_adr, a);
    check("chunk count", chunks.size(), n);
    if (wr) check("mask", seen_mask, m);
    if (n > 0 && m[3:0] != 0) check("low chunk", chunks[0],
      {1'b0, req_wdata[127:0]});
    if (n > 0 && m[7:4] != 0) check("high chunk", chunks[n-1],
      {1'b1, req_wdata[255:128]});
    if (k == SBS_REQ_READ || k == SBS_REQ_LOCKED) begin
      check("read beats", rd_cnt - rbase, 2);
      check("read data", seen_rd, mem_rdata);
      check("read check", rd_check_err, 1'b0);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    $display("ERROR watchdog expired");
    report_and_stop();
  end

  initial begin
    tick(8);
    rst = 1'b0;
    tick(2);
    run_op(SBS_REQ_WRITE, 32'h00001000, 8'hff, SBS_ACK_OK);
    check("cache writes", we_cnt > 0, 1'b1);
    cache_enabled = 1'b1;
    run_op(SBS_REQ_WRITE, 32'h00002020, 8'h0f, SBS_ACK_OK);
    // a clean write hit must be held off until the block turns shared
    cache_hit = 1'b1;
    req_kind = SBS_REQ_WRITE;
    req_valid = 1'b1;
    tick(30);
    check("held write starts", start_cnt, 2);
    req_valid = 1'b0;
    cache_shared = 1'b1;
    run_op(SBS_REQ_WRITE, 32'h00003040, 8'hf0, SBS_ACK_OK);
    run_op(SBS_REQ_COND_ST, 32'h00004000, 8'h03, SBS_ACK_OK);
    reject_cond_store = 1'b1;
    run_op(SBS_REQ_COND_ST, 32'h00004008, 8'h03,
      SBS_ACK_COND_REJECT);
    reject_cond_store = 1'b0;
    foreach (codes[j]) begin
      run_op(SBS_REQ_FETCH, 32'h00005000 + j, 8'h00, codes[j]);
      run_op(SBS_REQ_MOD_HINT, 32'h00006000 + j, 8'h00, codes[j]);
    end
    // ordering_sync_request must wait for the flush before it is acknowledged
    flush_done = 1'b0;
    fork
      begin
        tick(40);
        check("ordering_sync_request early", start_cnt - done_cnt, 1);
        flush_done = 1'b1;
      end
    join_none
    run_op(SBS_REQ_ORDERING_SYNC_REQUEST, 32'h00000000, 8'h00, SBS_ACK_SOFT_ERR);
    run_op(SBS_REQ_READ, 32'h00007000, 8'h00, SBS_ACK_OK);
    run_op(SBS_REQ_LOCKED, 32'h00008000, 8'h00, SBS_ACK_OK);
    report_and_stop();
  end
endmodule
